// ---- core/cef_change_det.v ----
/*
 change detector: pulses when a status field differs from its last sampled value.
 assumes the field is synchronous to sys_clk.
*/
`timescale 1ns/1ps

module cef_change_det #(
    parameter W = 1
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // field in, change pulse out
    input wire [W-1:0] field,
    output wire changed
);

reg [W-1:0] last_q;

// last value starts at zero, so a field that comes out of reset nonzero flags once
always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        last_q <= {W{1'b0}};
    end else begin
        last_q <= field;
    end
end

assign changed = |(last_q ^ field);

endmodule // cef_change_det

// ---- core/cef_defs.vh ----
/*
 charger event flag register constants: offsets, bit positions, reset values.
 assumes inclusion by the charger event flag logic only.
*/
`ifndef CEF_DEFS_VH
`define CEF_DEFS_VH

`define CEF_FLAGS_ADDR 8'h01
`define CEF_STAT_A_ADDR 8'h02
`define CEF_FLAGS_RESET 8'h00
`define CEF_BIT_RSVD 7
`define CEF_BIT_SYS_CFG 6
`define CEF_BIT_SYS_MIN 5
`define CEF_BIT_IN_LOOP 4
`define CEF_BIT_TJ_REG 3
`define CEF_BIT_IN_DTL 2
`define CEF_BIT_CHG_DTL 1
`define CEF_BIT_THM_DTL 0
`define CEF_STAT_BIT_VIN_MIN 6
`define CEF_STAT_BIT_IIN_LIM 5
`define CEF_STAT_BIT_SYS_MIN 4
`define CEF_STAT_BIT_TJ_REG 3
`define CEF_CHG_DTL_W 4
`define CEF_THM_DTL_W 3
`define CEF_IN_DTL_W 2

`endif

// ---- core/cef_flag_reg.v ----
/*
 charger event flag register with clear-on-read flags and the status-a register.
 the flag register latches charger events until it is read; status-a is a live
 view of the loop, regulation and thermistor levels; other addresses read zero.
 a read returns the flags as they stood before the strobe and clears them on the
 same edge; an event seen in that cycle is kept for the next read.
 assumes a serial register port outside that presents an 8-bit address with a
 one-cycle read strobe and samples the returned byte on the next cycle.
 assumes all status inputs are already synchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "cef_defs.vh"

module cef_flag_reg (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // charger analog status, synchronous levels
    input wire sysv_config_error,
    input wire sysv_min_loop_status,
    input wire input_min_voltage_loop_status,
    input wire input_current_limit_loop_status,
    input wire die_temp_regulation_status,
    input wire [`CEF_IN_DTL_W-1:0] input_detail_field,
    input wire [`CEF_CHG_DTL_W-1:0] charger_detail_field,
    input wire [`CEF_THM_DTL_W-1:0] thermistor_detail_field,
    // register port
    input wire reg_rd,
    input wire [7:0] reg_addr,
    output reg [7:0] reg_rdata,
    // flag levels for the interrupt logic outside
    output reg [7:0] charger_event_flags
);

wire in_loop_chg;
wire in_dtl_chg;
wire chg_dtl_chg;
wire thm_dtl_chg;
reg tj_q;
reg [7:0] ev;
reg [7:0] flags_d;
reg [7:0] stat_a;
reg [7:0] rdata_d;
wire rd_flags;
wire hit_flags;
wire sys_cfg_ev;
wire sys_min_ev;
wire tj_rise;

// one detector for both loop bits: a change of either sets the flag
cef_change_det #(.W(2)) u_in_loop (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .field({input_min_voltage_loop_status, input_current_limit_loop_status}),
    .changed(in_loop_chg)
);

// input detail field
cef_change_det #(.W(`CEF_IN_DTL_W)) u_in_dtl (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .field(input_detail_field),
    .changed(in_dtl_chg)
);

// charger detail field
cef_change_det #(.W(`CEF_CHG_DTL_W)) u_chg_dtl (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .field(charger_detail_field),
    .changed(chg_dtl_chg)
);

// thermistor detail field
cef_change_det #(.W(`CEF_THM_DTL_W)) u_thm_dtl (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .field(thermistor_detail_field),
    .changed(thm_dtl_chg)
);

always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        tj_q <= 1'b0;
    end else begin
        tj_q <= die_temp_regulation_status;
    end
end

assign hit_flags = (reg_addr == `CEF_FLAGS_ADDR);
assign rd_flags = reg_rd && hit_flags;

// both levels set their flags again after a read while the condition stands
assign sys_cfg_ev = sysv_config_error;
assign sys_min_ev = sysv_min_loop_status;
// only the rise counts; leaving regulation raises no flag
assign tj_rise = die_temp_regulation_status & ~tj_q;

always @* begin
    ev = 8'h00;
    ev[`CEF_BIT_SYS_CFG] = sys_cfg_ev;
    ev[`CEF_BIT_SYS_MIN] = sys_min_ev;
    ev[`CEF_BIT_IN_LOOP] = in_loop_chg;
    ev[`CEF_BIT_TJ_REG] = tj_rise;
    ev[`CEF_BIT_IN_DTL] = in_dtl_chg;
    ev[`CEF_BIT_CHG_DTL] = chg_dtl_chg;
    ev[`CEF_BIT_THM_DTL] = thm_dtl_chg;
end

// set wins over the read clear, so an event in the read cycle survives into the next read
always @* begin
    // reserved bit never sets
    flags_d[`CEF_BIT_RSVD] = 1'b0;

    // configuration error
    if (ev[`CEF_BIT_SYS_CFG]) begin
        flags_d[`CEF_BIT_SYS_CFG] = 1'b1;
    end else if (rd_flags) begin
        flags_d[`CEF_BIT_SYS_CFG] = 1'b0;
    end else begin
        flags_d[`CEF_BIT_SYS_CFG] = charger_event_flags[`CEF_BIT_SYS_CFG];
    end

    // minimum system loop engaged
    if (ev[`CEF_BIT_SYS_MIN]) begin
        flags_d[`CEF_BIT_SYS_MIN] = 1'b1;
    end else if (rd_flags) begin
        flags_d[`CEF_BIT_SYS_MIN] = 1'b0;
    end else begin
        flags_d[`CEF_BIT_SYS_MIN] = charger_event_flags[`CEF_BIT_SYS_MIN];
    end

    // input loop status change
    if (ev[`CEF_BIT_IN_LOOP]) begin
        flags_d[`CEF_BIT_IN_LOOP] = 1'b1;
    end else if (rd_flags) begin
        flags_d[`CEF_BIT_IN_LOOP] = 1'b0;
    end else begin
        flags_d[`CEF_BIT_IN_LOOP] = charger_event_flags[`CEF_BIT_IN_LOOP];
    end

    // rise into thermal regulation
    if (ev[`CEF_BIT_TJ_REG]) begin
        flags_d[`CEF_BIT_TJ_REG] = 1'b1;
    end else if (rd_flags) begin
        flags_d[`CEF_BIT_TJ_REG] = 1'b0;
    end else begin
        flags_d[`CEF_BIT_TJ_REG] = charger_event_flags[`CEF_BIT_TJ_REG];
    end

    // input detail change
    if (ev[`CEF_BIT_IN_DTL]) begin
        flags_d[`CEF_BIT_IN_DTL] = 1'b1;
    end else if (rd_flags) begin
        flags_d[`CEF_BIT_IN_DTL] = 1'b0;
    end else begin
        flags_d[`CEF_BIT_IN_DTL] = charger_event_flags[`CEF_BIT_IN_DTL];
    end

    // charger detail change
    if (ev[`CEF_BIT_CHG_DTL]) begin
        flags_d[`CEF_BIT_CHG_DTL] = 1'b1;
    end else if (rd_flags) begin
        flags_d[`CEF_BIT_CHG_DTL] = 1'b0;
    end else begin
        flags_d[`CEF_BIT_CHG_DTL] = charger_event_flags[`CEF_BIT_CHG_DTL];
    end

    // thermistor detail change
    if (ev[`CEF_BIT_THM_DTL]) begin
        flags_d[`CEF_BIT_THM_DTL] = 1'b1;
    end else if (rd_flags) begin
        flags_d[`CEF_BIT_THM_DTL] = 1'b0;
    end else begin
        flags_d[`CEF_BIT_THM_DTL] = charger_event_flags[`CEF_BIT_THM_DTL];
    end
end

always @* begin
    stat_a = 8'h00;
    stat_a[`CEF_STAT_BIT_VIN_MIN] = input_min_voltage_loop_status;
    stat_a[`CEF_STAT_BIT_IIN_LIM] = input_current_limit_loop_status;
    stat_a[`CEF_STAT_BIT_SYS_MIN] = sysv_min_loop_status;
    stat_a[`CEF_STAT_BIT_TJ_REG] = die_temp_regulation_status;
    stat_a[`CEF_THM_DTL_W-1:0] = thermistor_detail_field;
end

// unmapped addresses read as zero
always @* begin
    case (reg_addr)
        `CEF_FLAGS_ADDR: rdata_d = charger_event_flags;
        `CEF_STAT_A_ADDR: rdata_d = stat_a;
        default: rdata_d = 8'h00;
    endcase
end

always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        charger_event_flags <= `CEF_FLAGS_RESET;
    end else begin
        charger_event_flags <= flags_d;
    end
end

// read data holds between strobes, so a slow port may sample it late
always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        reg_rdata <= rdata_d;
    end
end

endmodule // cef_flag_reg

// ---- dv/cef_host.sv ----
/* host model: random reads; assumes random bits from the bench */
`timescale 1ns/1ps
module cef_host (
    // clock, reset, random bits
    input wire sys_clk, arst_n,
    input wire [3:0] rnd,
    // register port
    output reg reg_rd = 1'b0,
    output reg [7:0] reg_addr = 8'h00
);
    // addresses 0 and 3 are unmapped on purpose; strobes may run back to back
    always @(posedge sys_clk) begin
        reg_rd <= #1 arst_n & rnd[0] & rnd[1];
        reg_addr <= #1 {6'h00, rnd[3:2]};
    end
endmodule // cef_host

// ---- dv/cef_props.sv ----
/* flag checker; bound to cef_flag_reg */
`timescale 1ns/1ps
module cef_props (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // status levels
    input wire sysv_config_error,
    input wire sysv_min_loop_status,
    input wire input_min_voltage_loop_status,
    input wire input_current_limit_loop_status,
    input wire die_temp_regulation_status,
    // register port and flags
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire [7:0] charger_event_flags
);
    wire [7:0] f = charger_event_flags;
    wire [1:0] lp = {input_min_voltage_loop_status, input_current_limit_loop_status};
    wire rf = reg_rd && reg_addr == 8'h01;
    wire rs = reg_rd && reg_addr == 8'h02;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_B6: assert property (sysv_config_error |=> f[6]) else $error("b6");
    AST_B5: assert property (sysv_min_loop_status |=> f[5]) else $error("b5");
    AST_C5: assert property (rf && !sysv_min_loop_status |=> !f[5]) else $error("c5");
    AST_C6: assert property (rf && !sysv_config_error |=> !f[6]) else $error("c6");
    // pre-reset samples would fake a change at the first edge
    AST_B4: assert property ($past(arst_n) && $changed(lp) |=> f[4]) else $error("b4");
    AST_B3: assert property ($rose(die_temp_regulation_status) |=> f[3]) else $error("b3");
    AST_RD: assert property (rf |=> reg_rdata == $past(f)) else $error("rd");
    AST_ST: assert property (rs |=> reg_rdata[6:5] == $past(lp))
        else $error("st");
    cover property (rf && f[4]);
    cover property (reg_rd && reg_addr == 8'h03);
    cover property (rf && f == 8'h00);
endmodule // cef_props

// ---- dv/tb.sv ----
/* bench: random status, flag model, compare each cycle; assumes cef_host */
`timescale 1ns/1ps
module tb;
    reg sys_clk = 0, arst_n = 0;
    reg [16:0] r = 17'h15652;
    reg [13:0] c = 14'h0000, p;
    reg [7:0] m, d, ev;
    wire reg_rd;
    wire [7:0] reg_addr, rdata, fl;
    integer n_mismatch = 0, check_count = 0, i;
    cef_flag_reg dut (.sys_clk, .arst_n, .reg_rd, .reg_addr, .reg_rdata(rdata),
        .charger_event_flags(fl), .sysv_config_error(c[13]), .sysv_min_loop_status(c[12]),
        .input_min_voltage_loop_status(c[11]), .input_current_limit_loop_status(c[10]),
        .die_temp_regulation_status(c[9]), .input_detail_field(c[8:7]),
        .charger_detail_field(c[6:3]), .thermistor_detail_field(c[2:0]));
    cef_host host (.sys_clk, .arst_n, .rnd(r[3:0]), .reg_rd, .reg_addr);
    function [16:0] lf(input [16:0] v); lf = {v[15:0], v[16] ^ v[13]}; endfunction
    task cmp(input [39:0] nm, input [7:0] e, s);
        check_count = check_count + 1;
        if (s !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, s);
        end
    endtask
    task end_of_test;
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk or negedge arst_n)
        if (!arst_n) {m, d, p} <= 30'h0;
        else begin
            ev = {1'b0, c[13:12], c[11:10] != p[11:10], c[9] & ~p[9], c[8:7] != p[8:7],
                c[6:3] != p[6:3], c[2:0] != p[2:0]};
            if (reg_rd)
                d <= reg_addr == 8'h01 ? m :
                    reg_addr == 8'h02 ? {1'b0, c[11:10], c[12], c[9], c[2:0]} : 8'h00;
            // an event in the read cycle survives the clear
            m <= (reg_rd && reg_addr == 8'h01 ? 8'h00 : m) | ev;
            p <= c;
        end
    always @(negedge sys_clk) begin
        cmp("flags", m, fl);
        cmp("rdata", d, rdata);
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 arst_n = 1;
        // status moves only now and then, so quiet spells leave the change flags clear after a read; bits 6 and 5 follow their levels
        for (i = 0; i < 4000; i = i + 1) begin
            @(posedge sys_clk);
            #1 r = lf(r);
            // a reset in mid-run releases with live fields, so detectors restart from zero
            if (i == 2000) arst_n = 0;
            if (i == 2003) arst_n = 1;
            if (r[16:14] == 3'h0) c = r[13:0];
        end
        end_of_test;
    end
endmodule // tb
bind cef_flag_reg cef_props u_props (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sysv_config_error(sysv_config_error),
    .sysv_min_loop_status(sysv_min_loop_status),
    .input_min_voltage_loop_status(input_min_voltage_loop_status),
    .input_current_limit_loop_status(input_current_limit_loop_status),
    .die_temp_regulation_status(die_temp_regulation_status),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .charger_event_flags(charger_event_flags)
);
